// ===== rtl/sioflt_top.sv
`timescale 1ns/1ps
// How it works
// - input faults show input code alternating address
// - faulted terminal steady red, dual channel partner flashes red
// - discrepancy fault after configured time, config-only change
// - input fault clears: time, cause gone, input off
// - standard test output overload/stuck-high, no indicator
// - test output stuck-high clears: time, cause, input off
// - muting lamp terminal undercurrent gives test output code
// - output fault clears: time, cause gone, request off
// - dual channel differing program data gives violation
// - each cycle in which new faults appear raises one history record pulse
module sioflt_top (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [15:0] i_in_raw,
    input wire logic [7:0] i_in_dual,
    input sioflt_pkg::sioflt_cause_t i_cause_raw,
    input wire logic [3:0] i_to_standard,
    input wire logic i_to_muting_lamp,
    input wire logic [7:0] i_out_request,
    input wire logic [3:0] i_out_dual,
    input wire logic i_cfg_load,
    input wire logic [15:0] i_cfg_disc_ms,
    input wire logic [15:0] i_cfg_latch_ms,
    input wire logic i_hist_enable,
    input wire logic [7:0] i_node_addr,
    output logic [7:0] o_seg_value,
    output logic o_seg_is_addr,
    output logic [15:0] o_in_red_steady,
    output logic [15:0] o_in_red_flash,
    output logic [7:0] o_out_red_steady,
    output logic [7:0] o_out_red_flash,
    output logic o_red_phase,
    output logic [15:0] o_in_fault,
    output logic [3:0] o_to_fault,
    output logic o_lamp_fault,
    output logic [7:0] o_out_fault,
    output logic o_hist_wr
);
    localparam int unsigned NI = sioflt_pkg::N_IN;
    localparam int unsigned NO = sioflt_pkg::N_OUT;
    localparam int unsigned NT = sioflt_pkg::N_TO;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [15:0] in_s1_r;
    logic [15:0] in_s2_r;
    sioflt_pkg::sioflt_cause_t cause_s1_r;
    sioflt_pkg::sioflt_cause_t cause_s2_r;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            in_s1_r <= '0;
            in_s2_r <= '0;
            cause_s1_r <= '0;
            cause_s2_r <= '0;
        end else begin
            in_s1_r <= i_in_raw;
            in_s2_r <= in_s1_r;
            cause_s1_r <= i_cause_raw;
            cause_s2_r <= cause_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] disc_ms;
        logic [15:0] latch_ms;
        logic [17:0] ms_cnt;
        logic [27:0] alt_cnt;
        logic show_addr;
        logic [25:0] flash_cnt;
        logic flash;
        logic [7:0][15:0] disc_cnt;
        logic [7:0] seg;
        logic [32:0] prev_faults;
        logic hist;
    } sioflt_st_t;
    sioflt_st_t st_r;
    sioflt_st_t st_nxt;

    logic ms_tick;
    assign ms_tick = (st_r.ms_cnt == 18'(sioflt_pkg::MS_CYCLES - 1));

    // ----------------------------------------------------------------
    // discrepancy detection and causes
    // ----------------------------------------------------------------
    logic [7:0] disc_cause;
    logic [NI-1:0] in_cause;
    logic [NT-1:0] to_oc_cause;
    logic [NT-1:0] to_sh_cause;
    logic lamp_cause;
    logic [NO-1:0] out_cause;
    logic [NO-1:0] dual_viol;
    logic [NI-1:0] in_pair_bad;
    logic [NO-1:0] out_pair_bad;
    logic [NI-1:0] in_flt;
    logic [NT-1:0] to_oc_flt;
    logic [NT-1:0] to_sh_flt;
    logic lamp_flt;
    logic [NO-1:0] out_flt;

    genvar g;
    generate
        for (g = 0; g < NI / 2; g++) begin : g_inpair
            assign disc_cause[g] = i_in_dual[g]
                && (in_s2_r[2*g] != in_s2_r[2*g+1])
                && (st_r.disc_cnt[g] >= st_r.disc_ms);
            assign in_pair_bad[2*g] = disc_cause[g];
            assign in_pair_bad[2*g+1] = disc_cause[g];
        end
        for (g = 0; g < NI; g++) begin : g_in
            assign in_cause[g] = cause_s2_r.in_test_fail[g]
                | cause_s2_r.in_internal_fail[g] | in_pair_bad[g];
            sioflt_latch u_lat (
                .i_clk_sys(i_clk_sys),
                .i_resetn(i_resetn),
                .i_cause(in_cause[g]),
                .i_signal_on(in_s2_r[g]),
                .i_ms_tick(ms_tick),
                .i_latch_ms(st_r.latch_ms),
                .o_fault(in_flt[g])
            );
        end
        for (g = 0; g < NT; g++) begin : g_to
            assign to_oc_cause[g] = i_to_standard[g] & cause_s2_r.to_overload[g];
            assign to_sh_cause[g] = i_to_standard[g] & cause_s2_r.to_stuck_high[g];
            sioflt_latch u_oc (
                .i_clk_sys(i_clk_sys),
                .i_resetn(i_resetn),
                .i_cause(to_oc_cause[g]),
                .i_signal_on(1'b0),
                .i_ms_tick(ms_tick),
                .i_latch_ms(st_r.latch_ms),
                .o_fault(to_oc_flt[g])
            );
            sioflt_latch u_sh (
                .i_clk_sys(i_clk_sys),
                .i_resetn(i_resetn),
                .i_cause(to_sh_cause[g]),
                .i_signal_on(|in_s2_r),
                .i_ms_tick(ms_tick),
                .i_latch_ms(st_r.latch_ms),
                .o_fault(to_sh_flt[g])
            );
        end
        for (g = 0; g < NO / 2; g++) begin : g_outpair
            assign dual_viol[2*g] = i_out_dual[g]
                && (i_out_request[2*g] != i_out_request[2*g+1]);
            assign dual_viol[2*g+1] = dual_viol[2*g];
        end
        for (g = 0; g < NO; g++) begin : g_out
            assign out_cause[g] = cause_s2_r.out_overcurrent[g] | cause_s2_r.out_short[g]
                | cause_s2_r.out_stuck_high[g] | cause_s2_r.out_cross[g]
                | dual_viol[g];
            sioflt_latch u_lat (
                .i_clk_sys(i_clk_sys),
                .i_resetn(i_resetn),
                .i_cause(out_cause[g]),
                .i_signal_on(i_out_request[g]),
                .i_ms_tick(ms_tick),
                .i_latch_ms(st_r.latch_ms),
                .o_fault(out_flt[g])
            );
            assign out_pair_bad[g] = out_flt[g ^ 1] & i_out_dual[g/2];
        end
    endgenerate

    assign lamp_cause = i_to_muting_lamp
        & cause_s2_r.to_lamp_undercurrent;
    sioflt_latch u_lamp (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_cause(lamp_cause),
        .i_signal_on(1'b0),
        .i_ms_tick(ms_tick),
        .i_latch_ms(st_r.latch_ms),
        .o_fault(lamp_flt)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [32:0] all_faults;
    logic [NI-1:0] in_partner;
    assign all_faults = {in_flt, to_oc_flt, to_sh_flt, lamp_flt, out_flt};

    always_comb begin
        st_nxt = st_r;
        if (i_cfg_load) begin
            st_nxt.disc_ms = i_cfg_disc_ms;
            st_nxt.latch_ms = i_cfg_latch_ms;
        end
        st_nxt.ms_cnt = ms_tick ? 18'h00000 : st_r.ms_cnt + 18'h00001;
        for (int i = 0; i < NI / 2; i++) begin
            if (in_s2_r[2*i] == in_s2_r[2*i+1]) begin
                st_nxt.disc_cnt[i] = sioflt_pkg::CNT_RST;
            end else if (ms_tick && st_r.disc_cnt[i] != 16'hffff) begin
                st_nxt.disc_cnt[i] = st_r.disc_cnt[i] + 16'h0001;
            end
        end
        if (st_r.alt_cnt == 28'(sioflt_pkg::ALT_CYCLES - 1)) begin
            st_nxt.alt_cnt = '0;
            st_nxt.show_addr = ~st_r.show_addr;
        end else begin
            st_nxt.alt_cnt = st_r.alt_cnt + 28'h0000001;
        end
        if (st_r.flash_cnt == 26'(sioflt_pkg::FLASH_CYCLES - 1)) begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash = ~st_r.flash;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 26'h0000001;
        end
        if (|in_flt) begin
            st_nxt.seg = sioflt_pkg::INPUT_FAULT_CODE;
        end else if (|{to_oc_flt, to_sh_flt, lamp_flt}) begin
            st_nxt.seg = sioflt_pkg::TEST_OUTPUT_FAULT_CODE;
        end else if (|out_flt) begin
            st_nxt.seg = sioflt_pkg::OUTPUT_FAULT_CODE;
        end else begin
            st_nxt.seg = sioflt_pkg::NO_CODE;
            st_nxt.show_addr = 1'b0;
            st_nxt.alt_cnt = '0;
        end
        // same phase as the address flag registered alongside
        if (st_nxt.show_addr && st_nxt.seg != sioflt_pkg::NO_CODE) begin
            st_nxt.seg = i_node_addr;
        end
        st_nxt.prev_faults = all_faults;
        st_nxt.hist = i_hist_enable && |(all_faults & ~st_r.prev_faults);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            st_r <= '0;
            st_r.disc_ms <= 16'(sioflt_pkg::DISC_MS_DEFAULT);
            st_r.latch_ms <= 16'(sioflt_pkg::LATCH_MS_DEFAULT);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    generate
        for (g = 0; g < NI; g++) begin : g_inled
            assign in_partner[g] = in_flt[g ^ 1] & i_in_dual[g/2];
        end
    endgenerate

    assign o_seg_value = st_r.seg;
    assign o_seg_is_addr = st_r.show_addr;
    assign o_in_red_steady = in_flt;
    assign o_in_red_flash = in_partner & ~in_flt & {NI{st_r.flash}};
    assign o_out_red_steady = out_flt;
    assign o_out_red_flash = out_pair_bad & ~out_flt & {NO{st_r.flash}};
    assign o_red_phase = st_r.flash;
    assign o_in_fault = in_flt;
    assign o_to_fault = to_oc_flt | to_sh_flt;
    assign o_lamp_fault = lamp_flt;
    assign o_out_fault = out_flt;
    assign o_hist_wr = st_r.hist;
endmodule

// ===== inc/sioflt_pkg.sv
package sioflt_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned N_IN = 16;
    localparam int unsigned N_TO = 4;
    localparam int unsigned N_OUT = 8;
    localparam logic [1:0] MUTING_LAMP_TERMINAL = 2'h3;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned ALT_MS = 1000;
    localparam int unsigned ALT_CYCLES = ALT_MS * 1000 * CLK_MHZ;
    localparam int unsigned FLASH_MS = 250;
    localparam int unsigned FLASH_CYCLES = FLASH_MS * 1000 * CLK_MHZ;
    localparam int unsigned DISC_MS_DEFAULT = 300;
    localparam int unsigned LATCH_MS_DEFAULT = 1000;
    localparam int unsigned MS_CYCLES = 1000 * CLK_MHZ;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // ----------------------------------------------------------------
    // display codes: high nibble letter, low nibble digit
    // ----------------------------------------------------------------
    localparam logic [7:0] INPUT_FAULT_CODE = 8'hf1;
    localparam logic [7:0] TEST_OUTPUT_FAULT_CODE = 8'hf2;
    localparam logic [7:0] OUTPUT_FAULT_CODE = 8'hf3;
    localparam logic [7:0] NO_CODE = 8'h00;

    typedef enum logic [1:0] {
        SIOFLT_SRC_NONE,
        SIOFLT_SRC_IN,
        SIOFLT_SRC_TO,
        SIOFLT_SRC_OUT
    } sioflt_src_t;

    typedef struct packed {
        logic [7:0] code;
        logic show_addr;
        logic active;
    } sioflt_disp_t;

    // per fault class detector results from the field interface
    typedef struct packed {
        logic [N_IN-1:0] in_test_fail;
        logic [N_IN-1:0] in_internal_fail;
        logic [N_TO-1:0] to_overload;
        logic [N_TO-1:0] to_stuck_high;
        logic to_lamp_undercurrent;
        logic [N_OUT-1:0] out_overcurrent;
        logic [N_OUT-1:0] out_short;
        logic [N_OUT-1:0] out_stuck_high;
        logic [N_OUT-1:0] out_cross;
    } sioflt_cause_t;
endpackage

// ===== rtl/sioflt_latch.sv
`timescale 1ns/1ps
// one latched fault with latch time, cause and signal-off release
module sioflt_latch (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_cause,
    input wire logic i_signal_on,
    input wire logic i_ms_tick,
    input wire logic [15:0] i_latch_ms,
    output logic o_fault
);
    typedef struct packed {
        logic fault;
        logic [15:0] cnt;
    } sioflt_lst_t;
    sioflt_lst_t st_r;
    sioflt_lst_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_cause) begin
            st_nxt.fault = 1'b1;
            st_nxt.cnt = sioflt_pkg::CNT_RST;
        end else if (st_r.fault) begin
            if (i_ms_tick && st_r.cnt < i_latch_ms) begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
            if (st_r.cnt >= i_latch_ms && !i_signal_on) begin
                st_nxt.fault = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_fault = st_r.fault;
endmodule

// ===== tb/sioflt_top_asserts.sv
`timescale 1ns/1ps
module sioflt_top_asserts (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [15:0] i_in_raw,
    input wire logic [7:0] i_out_request,
    input wire logic [3:0] i_out_dual,
    input wire logic [7:0] o_seg_value,
    input wire logic o_seg_is_addr,
    input wire logic [15:0] o_in_red_steady,
    input wire logic [15:0] o_in_red_flash,
    input wire logic [15:0] o_in_fault,
    input wire logic [3:0] o_to_fault,
    input wire logic o_lamp_fault,
    input wire logic [7:0] o_out_fault,
    input wire logic o_hist_wr
);
    // --------
    // helpers
    // --------
    logic [15:0] pair_on;
    logic [3:0] ev;
    logic [3:0] od;
    logic in_a, to_a, out_a, any_a;
    assign pair_on = ((o_in_red_steady & 16'h5555) << 1) | ((o_in_red_steady >> 1) & 16'h5555);
    assign ev = {i_out_request[6], i_out_request[4], i_out_request[2], i_out_request[0]};
    assign od = {i_out_request[7], i_out_request[5], i_out_request[3], i_out_request[1]};
    assign in_a = |o_in_fault;
    assign to_a = (|o_to_fault) | o_lamp_fault;
    assign out_a = |o_out_fault;
    assign any_a = in_a | to_a | out_a;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // --------
    // properties
    // --------
    property p_code_in;
        $past(in_a) && in_a && !o_seg_is_addr |-> o_seg_value == sioflt_pkg::INPUT_FAULT_CODE;
    endproperty
    a_code_in: assert property (p_code_in) else $error("input code missing");
    property p_in_red;
        $rose(in_a) |-> ##[0:1] (o_in_red_steady & o_in_fault) != 16'h0000;
    endproperty
    a_in_red: assert property (p_in_red) else $error("input red missing");
    property p_flash;
        (o_in_red_flash & ~pair_on & ~$past(pair_on)) == 16'h0000;
    endproperty
    a_flash: assert property (p_flash) else $error("flash without partner");
    property p_code_to;
        $past(to_a) && to_a && !in_a && !$past(in_a) && !o_seg_is_addr
            |-> o_seg_value == sioflt_pkg::TEST_OUTPUT_FAULT_CODE;
    endproperty
    a_code_to: assert property (p_code_to) else $error("test output code missing");
    property p_code_out;
        $past(out_a) && out_a && !in_a && !to_a && !$past(in_a) && !$past(to_a)
            && !o_seg_is_addr |-> o_seg_value == sioflt_pkg::OUTPUT_FAULT_CODE;
    endproperty
    a_code_out: assert property (p_code_out) else $error("output code missing");
    property p_dual;
        (|(i_out_dual & (ev ^ od))) |-> ##[1:2] out_a;
    endproperty
    a_dual: assert property (p_dual) else $error("dual violation missed");
    property p_hist;
        o_hist_wr |-> $past(any_a);
    endproperty
    a_hist: assert property (p_hist) else $error("history pulse without fault");
    property p_in_hold;
        ($past(o_in_fault) & ~o_in_fault & $past(i_in_raw, 3)) == 16'h0000;
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input fault cleared while on");
    property p_out_hold;
        ($past(o_out_fault) & ~o_out_fault & $past(i_out_request)) == 8'h00;
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output fault cleared early");
endmodule

bind sioflt_top sioflt_top_asserts i_chk (
    .i_clk_sys, .i_resetn, .i_in_raw, .i_out_request, .i_out_dual, .o_seg_value,
    .o_seg_is_addr, .o_in_red_steady, .o_in_red_flash, .o_in_fault, .o_to_fault,
    .o_lamp_fault, .o_out_fault, .o_hist_wr
);

// ===== tb/sioflt_field.sv
`timescale 1ns/1ps
module sioflt_field (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_want,
    input wire logic i_break,
    output logic [7:0] o_request = 8'h00
);
    // --------
    // user program outputs
    // --------
    logic [7:0] eq;
    assign eq = i_want | ((i_want & 8'h55) << 1) | ((i_want >> 1) & 8'h55);
    // program scan updates on the rising edge, after the bench has set its wishes
    always @(posedge i_clk_sys) begin
        o_request <= i_break ? i_want : eq;
    end
endmodule

// ===== tb/sioflt_top_bench.sv
`timescale 1ns/1ps
module sioflt_top_bench;
    // --------
    // stimulus
    // --------
    typedef struct packed {
        logic [3:0] cls;
        logic [3:0] idx;
        logic [7:0] code;
    } sioflt_row_t;
    localparam logic [7:0] FI = sioflt_pkg::INPUT_FAULT_CODE;
    localparam logic [7:0] FT = sioflt_pkg::TEST_OUTPUT_FAULT_CODE;
    localparam logic [7:0] FO = sioflt_pkg::OUTPUT_FAULT_CODE;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic cfg_load = 1'b0;
    logic brk = 1'b0;
    logic hist_en = 1'b1;
    logic [15:0] cfg_ms = 16'h0000;
    logic [15:0] in_raw = 16'h0000;
    logic [7:0] want = 8'h00;
    logic [7:0] out_req;
    sioflt_pkg::sioflt_cause_t cause = '0;
    logic [7:0] seg, out_st, out_f;
    logic seg_addr, lamp_f, hist;
    logic [15:0] in_st, in_f;
    logic [3:0] to_f;
    logic [15:0] in_fl;
    logic [7:0] out_fl;
    logic phase;
    int miscompares = 0;
    int cmp_count = 0;
    sioflt_row_t r;
    sioflt_row_t rows [9] = '{'{4'h0, 4'h2, FI}, '{4'h1, 4'h9, FI}, '{4'h2, 4'h0, FT},
        '{4'h3, 4'h1, FT}, '{4'h4, 4'h3, FT}, '{4'h5, 4'h4, FO}, '{4'h6, 4'h5, FO},
        '{4'h7, 4'h2, FO}, '{4'h8, 4'h7, FO}};

    always #2.5 i_clk_sys = ~i_clk_sys;

    sioflt_field i_field (.i_clk_sys(i_clk_sys), .i_want(want), .i_break(brk), .o_request(out_req));
    sioflt_top i_dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_in_raw(in_raw),
        .i_in_dual(8'h0f), .i_cause_raw(cause), .i_to_standard(4'h7), .i_to_muting_lamp(1'b1),
        .i_out_request(out_req), .i_out_dual(4'h1), .i_cfg_load(cfg_load),
        .i_cfg_disc_ms(cfg_ms), .i_cfg_latch_ms(cfg_ms), .i_hist_enable(hist_en),
        .i_node_addr(8'h2a), .o_seg_value(seg), .o_seg_is_addr(seg_addr),
        .o_in_red_steady(in_st), .o_in_red_flash(in_fl), .o_out_red_steady(out_st),
        .o_out_red_flash(out_fl), .o_red_phase(phase), .o_in_fault(in_f), .o_to_fault(to_f),
        .o_lamp_fault(lamp_f), .o_out_fault(out_f), .o_hist_wr(hist));

    function automatic sioflt_pkg::sioflt_cause_t mk(input sioflt_row_t x);
        sioflt_pkg::sioflt_cause_t c;
        c = '0;
        case (x.cls)
            4'h0: c.in_test_fail[x.idx] = 1'b1;
            4'h1: c.in_internal_fail[x.idx] = 1'b1;
            4'h2: c.to_overload[x.idx[1:0]] = 1'b1;
            4'h3: c.to_stuck_high[x.idx[1:0]] = 1'b1;
            4'h4: c.to_lamp_undercurrent = 1'b1;
            4'h5: c.out_overcurrent[x.idx[2:0]] = 1'b1;
            4'h6: c.out_short[x.idx[2:0]] = 1'b1;
            4'h7: c.out_stuck_high[x.idx[2:0]] = 1'b1;
            default: c.out_cross[x.idx[2:0]] = 1'b1;
        endcase
        return c;
    endfunction

    function automatic logic fault_of(input sioflt_row_t x);
        if (x.cls < 4'h2) return in_f[x.idx];
        if (x.cls < 4'h4) return to_f[x.idx[1:0]];
        if (x.cls == 4'h4) return lamp_f;
        return out_f[x.idx[2:0]];
    endfunction

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_for(input sioflt_row_t x, input logic v);
        for (int n = 0; n < 2000 && fault_of(x) !== v; n++) @(negedge i_clk_sys);
    endtask

    task automatic hold_test(input sioflt_row_t x, input logic [15:0] pins, input logic [7:0] q);
        in_raw = pins;
        want = q;
        cause = mk(x);
        wait_for(x, 1'b1);
        cause = '0;
        repeat (20) @(negedge i_clk_sys);
        check(fault_of(x) === 1'b1, "fault released while signal on");
        in_raw = 16'h0000;
        want = 8'h00;
        wait_for(x, 1'b0);
        check(fault_of(x) === 1'b0, "fault not released");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_clk_sys);
        miscompares++;
        test_done();
    end

    // --------
    // tests
    // --------
    initial begin
        repeat (12) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        @(negedge i_clk_sys);
        check(in_st === 16'h0 && out_f === 8'h0 && seg === sioflt_pkg::NO_CODE, "reset");
        check(in_fl === 16'h0 && out_fl === 8'h0 && phase === 1'b0, "flash at reset");
        check(seg_addr === 1'b0 && hist === 1'b0, "address or history at reset");
        in_raw = 16'h0001;
        repeat (200) @(negedge i_clk_sys);
        check(in_f === 16'h0000, "discrepancy time changed without load");
        in_raw = 16'h0000;
        cfg_load = 1'b1;
        @(negedge i_clk_sys);
        cfg_load = 1'b0;
        in_raw = 16'h0010;
        for (int n = 0; n < 2000 && in_f[5:4] !== 2'b11; n++) @(negedge i_clk_sys);
        check(in_f[5:4] === 2'b11, "discrepancy missed");
        in_raw = 16'h0000;
        for (int n = 0; n < 2000 && in_f !== 16'h0; n++) @(negedge i_clk_sys);
        foreach (rows[k]) begin
            r = rows[k];
            cause = mk(r);
            wait_for(r, 1'b1);
            @(negedge i_clk_sys);
            check(fault_of(r) === 1'b1 && hist === 1'b1, "fault or history");
            check(seg === r.code, "display code");
            check(seg_addr === 1'b0, "address phase too early");
            if (r.cls < 4'h2) check(in_st[r.idx] === 1'b1, "input led");
            else if (r.cls < 4'h5) check(in_st === 16'h0 && out_st === 8'h0, "led lit");
            else check(out_st[r.idx[2:0]] === 1'b1, "output led");
            cause = '0;
            wait_for(r, 1'b0);
            check(fault_of(r) === 1'b0, "fault not released");
        end
        hold_test(sioflt_row_t'{4'h0, 4'hc, 8'h00}, 16'h1000, 8'h00);
        hold_test(sioflt_row_t'{4'h3, 4'h2, 8'h00}, 16'h1000, 8'h00);
        hold_test(sioflt_row_t'{4'h5, 4'h4, 8'h00}, 16'h0000, 8'h10);
        brk = 1'b1;
        want = 8'h01;
        repeat (5) @(negedge i_clk_sys);
        check(out_f[1:0] === 2'b11 && seg === FO, "dual violation");
        brk = 1'b0;
        want = 8'h00;
        for (int n = 0; n < 2000 && out_f !== 8'h00; n++) @(negedge i_clk_sys);
        check(out_f === 8'h00, "dual fault stuck");
        hist_en = 1'b0;
        cause = mk(rows[0]);
        wait_for(rows[0], 1'b1);
        @(negedge i_clk_sys);
        check(hist === 1'b0, "history while disabled");
        i_resetn = 1'b0;
        cause = '0;
        repeat (2) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        @(negedge i_clk_sys);
        check(in_f === 16'h0000, "reset in mid run");
        test_done();
    end
endmodule
